// ---- event_timer_pkg.sv ----
// Functional notes
// [RULE_01] Timer and pulse modes count system clock/4
// [RULE_02] Event mode counts selected edge of input
// [RULE_03] Overflow past FFFFH reloads preload, raises request
// [RULE_04] Stopped: preload write also loads count
// [RULE_05] Running: new preload waits for next overflow
// [RULE_06] Low byte write goes to holding buffer
// [RULE_07] High byte write moves buffer into low
// [RULE_08] High read latches low; low read returns latch
// [RULE_09] Software writes low byte before high byte
// [RULE_10] Mode bits: 10 timer, 01 event, 11 pulse
// [RULE_11] Run enable bit 4 starts and stops counting
// [RULE_12] Edge sense bit 3 picks edge or level
// [RULE_13] Timer mode increments on each prescaler tick; the code skips ticks while power_down is high
// [RULE_14] Overflow request gated by interrupt enable bit
// [RULE_15] Event counting continues during power down
// [RULE_16] Pulse, sense low: count while pin low
// [RULE_17] Pulse, sense high: count while pin high
// [RULE_18] Outside pulse mode only software clears run
// [RULE_19] After measurement, hold count until rerun
// [RULE_20] Software selects mode and sets pin input
// [RULE_21] Input pin synchronised before edge detection
package event_timer_pkg;

  localparam int          AXI_ADDR_W   = 8;
  localparam logic [7:0]  OFS_LOW      = 8'h00;
  localparam logic [7:0]  OFS_HIGH     = 8'h04;
  localparam logic [7:0]  OFS_CTRL     = 8'h08;
  localparam logic [7:0]  OFS_IRQ_EN   = 8'h0c;

  localparam int          BIT_MODE_HI  = 7;
  localparam int          BIT_MODE_LO  = 6;
  localparam int          BIT_RUN      = 4;
  localparam int          BIT_EDGE     = 3;
  localparam int          BIT_IRQ_EN   = 0;

  localparam int          PRESCALE_DIV = 4;
  localparam logic [1:0]  PRESCALE_LAST = 2'(PRESCALE_DIV - 1);
  localparam logic [15:0] COUNT_FULL   = 16'hffff;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [7:0]  CTRL_RST     = 8'h00;

  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [1:0] {
    MODE_NONE  = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_PULSE = 2'b11
  } mode_t;

  typedef enum logic {
    PW_WAIT = 1'b0,
    PW_MEAS = 1'b1
  } pw_state_t;

endpackage : event_timer_pkg

// ---- event_timer.sv ----
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module event_timer (
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic [event_timer_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                            s_axi_awprot,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  input  wire logic [event_timer_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                            s_axi_arprot,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  input  wire logic                                  event_input_pin,
  input  wire logic                                  power_down,
  output logic                                       overflow_irq
);

  typedef struct packed {
    logic                       sync1;
    logic                       sync2;
    logic                       pin_prev;
    logic [1:0]                 div;
    logic [15:0]                count;
    logic [15:0]                preload;
    logic [7:0]                 low_buf;
    event_timer_pkg::mode_t     mode;
    logic                       run_enable;
    logic                       edge_sense_bit;
    logic                       overflow_irq_mask;
    event_timer_pkg::pw_state_t pw_st;
    logic                       ovf;
    logic                       irq;
    logic                       aw_have;
    logic [7:0]                 awaddr;
    logic                       w_have;
    logic [7:0]                 wdata;
    logic                       wstrb0;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [7:0]                 rdata;
    logic [1:0]                 rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic       tick;
  logic       pin_rise;
  logic       pin_fall;
  logic       start_edge;
  logic       back_level;
  logic       inc;
  logic       do_wr;
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_ctrl;
  logic       wr_mask;
  logic       rd_take;
  logic       rd_hi;

  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] ofs);
    reg_hit = (a[7:2] == ofs[7:2]);
  endfunction : reg_hit

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = reg_hit(a, event_timer_pkg::OFS_LOW)
               | reg_hit(a, event_timer_pkg::OFS_HIGH)
               | reg_hit(a, event_timer_pkg::OFS_CTRL)
               | reg_hit(a, event_timer_pkg::OFS_IRQ_EN);
  endfunction : reg_mapped

  assign s_axi_awready = ~st_r.aw_have;
  assign s_axi_wready  = ~st_r.w_have;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rresp   = st_r.rresp;
  assign s_axi_rdata   = {24'h000000, st_r.rdata};
  assign overflow_irq  = st_r.irq;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ovf = 1'b0;
    st_nxt.irq = 1'b0;

    // Two-flop synchroniser; only the second stage feeds edge logic
    st_nxt.sync1    = event_input_pin; // RULE_21
    st_nxt.sync2    = st_r.sync1;
    st_nxt.pin_prev = st_r.sync2;
    pin_rise = st_r.sync2 & ~st_r.pin_prev;
    pin_fall = ~st_r.sync2 & st_r.pin_prev;

    // Free-running prescaler; tick marks the falling edge of clk/4
    st_nxt.div = st_r.div + 2'h1; // RULE_01
    tick = (st_r.div == event_timer_pkg::PRESCALE_LAST); // RULE_13

    // Sense low: falling edge starts, high level ends; high mirrors
    start_edge = st_r.edge_sense_bit ? pin_rise : pin_fall; // RULE_12
    back_level = st_r.edge_sense_bit ? ~st_r.sync2 : st_r.sync2;

    inc = 1'b0;
    case (st_r.mode) // RULE_10
      event_timer_pkg::MODE_TIMER: begin
        // Clock stops in power down, so the timer count halts; the prescaler keeps running
        inc = st_r.run_enable & tick & ~power_down; // RULE_13
      end
      event_timer_pkg::MODE_EVENT: begin
        // Pin edges count even while the processor sleeps
        inc = st_r.run_enable
            & (st_r.edge_sense_bit ? pin_fall : pin_rise); // RULE_02 RULE_15
      end
      event_timer_pkg::MODE_PULSE: begin
        if (st_r.run_enable) begin
          case (st_r.pw_st)
            event_timer_pkg::PW_WAIT: begin
              if (start_edge) begin
                st_nxt.pw_st = event_timer_pkg::PW_MEAS; // RULE_16 RULE_17
              end
            end
            event_timer_pkg::PW_MEAS: begin
              if (back_level) begin
                // Single shot: later edges ignored until rerun
                st_nxt.run_enable = 1'b0; // RULE_16 RULE_17 RULE_19
                st_nxt.pw_st      = event_timer_pkg::PW_WAIT;
              end else begin
                inc = tick & ~power_down; // RULE_01
              end
            end
            default: begin
              st_nxt.pw_st = event_timer_pkg::PW_WAIT;
            end
          endcase
        end
      end
      default: begin
        inc = 1'b0;
      end
    endcase

    if (inc) begin
      if (st_r.count == event_timer_pkg::COUNT_FULL) begin
        st_nxt.count = st_r.preload; // RULE_03 RULE_05
        st_nxt.ovf   = 1'b1; // RULE_03
        st_nxt.irq   = st_r.overflow_irq_mask; // RULE_14
      end else begin
        st_nxt.count = st_r.count + 16'h0001;
      end
    end

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !st_r.aw_have) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_have) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata  = s_axi_wdata[7:0];
      st_nxt.wstrb0 = s_axi_wstrb[0];
    end
    do_wr   = st_r.aw_have & st_r.w_have & ~st_r.bvalid;
    wr_lo   = do_wr & st_r.wstrb0
            & reg_hit(st_r.awaddr, event_timer_pkg::OFS_LOW);
    wr_hi   = do_wr & st_r.wstrb0
            & reg_hit(st_r.awaddr, event_timer_pkg::OFS_HIGH);
    wr_ctrl = do_wr & st_r.wstrb0
            & reg_hit(st_r.awaddr, event_timer_pkg::OFS_CTRL);
    wr_mask = do_wr & st_r.wstrb0
            & reg_hit(st_r.awaddr, event_timer_pkg::OFS_IRQ_EN);

    // Read channel; high byte read snapshots the live low byte
    rd_take = s_axi_arvalid & ~st_r.rvalid;
    rd_hi   = rd_take & reg_hit(s_axi_araddr, event_timer_pkg::OFS_HIGH);
    if (rd_hi) begin
      st_nxt.low_buf = st_r.count[7:0]; // RULE_08
    end
    if (rd_take) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = reg_mapped(s_axi_araddr) ?
                      event_timer_pkg::RESP_OKAY :
                      event_timer_pkg::RESP_SLVERR;
      st_nxt.rdata  = 8'h00;
      if (reg_hit(s_axi_araddr, event_timer_pkg::OFS_LOW)) begin
        st_nxt.rdata = st_r.low_buf; // RULE_08
      end else if (reg_hit(s_axi_araddr, event_timer_pkg::OFS_HIGH)) begin
        st_nxt.rdata = st_r.count[15:8];
      end else if (reg_hit(s_axi_araddr, event_timer_pkg::OFS_CTRL)) begin
        st_nxt.rdata[event_timer_pkg::BIT_MODE_HI] = st_r.mode[1];
        st_nxt.rdata[event_timer_pkg::BIT_MODE_LO] = st_r.mode[0];
        st_nxt.rdata[event_timer_pkg::BIT_RUN]     = st_r.run_enable;
        st_nxt.rdata[event_timer_pkg::BIT_EDGE]    = st_r.edge_sense_bit;
      end else if (reg_hit(s_axi_araddr, event_timer_pkg::OFS_IRQ_EN)) begin
        st_nxt.rdata[event_timer_pkg::BIT_IRQ_EN] = st_r.overflow_irq_mask;
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    if (wr_lo) begin
      // Low byte parks in the buffer; a pending high read loses
      st_nxt.low_buf = st_r.wdata; // RULE_06
    end
    if (wr_hi) begin
      st_nxt.preload = {st_r.wdata, st_r.low_buf}; // RULE_07
      if (!st_r.run_enable) begin
        st_nxt.count = {st_r.wdata, st_r.low_buf}; // RULE_04
      end
    end
    if (wr_ctrl) begin // RULE_18
      // Software write overrides a same-cycle hardware stop
      st_nxt.mode           = event_timer_pkg::mode_t'(
        {st_r.wdata[event_timer_pkg::BIT_MODE_HI],
         st_r.wdata[event_timer_pkg::BIT_MODE_LO]}); // RULE_10
      st_nxt.run_enable     = st_r.wdata[event_timer_pkg::BIT_RUN]; // RULE_11
      st_nxt.edge_sense_bit = st_r.wdata[event_timer_pkg::BIT_EDGE]; // RULE_12
      st_nxt.pw_st          = event_timer_pkg::PW_WAIT;
    end
    if (wr_mask) begin
      st_nxt.overflow_irq_mask =
        st_r.wdata[event_timer_pkg::BIT_IRQ_EN]; // RULE_14
    end
    if (do_wr) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = reg_mapped(st_r.awaddr) ?
                       event_timer_pkg::RESP_OKAY :
                       event_timer_pkg::RESP_SLVERR;
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r                   <= '0;
      st_r.count             <= event_timer_pkg::COUNT_RST;
      st_r.preload           <= event_timer_pkg::COUNT_RST;
      st_r.mode              <= event_timer_pkg::mode_t'(
        {event_timer_pkg::CTRL_RST[event_timer_pkg::BIT_MODE_HI],
         event_timer_pkg::CTRL_RST[event_timer_pkg::BIT_MODE_LO]});
      st_r.run_enable        <=
        event_timer_pkg::CTRL_RST[event_timer_pkg::BIT_RUN];
      st_r.edge_sense_bit    <=
        event_timer_pkg::CTRL_RST[event_timer_pkg::BIT_EDGE];
    end else begin
      st_r <= st_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_timer_prescale: assert property ( // RULE_01
    (st_r.mode == event_timer_pkg::MODE_TIMER && inc) |->
      st_r.div == event_timer_pkg::PRESCALE_LAST)
    else $error("timer counted off the prescaler tick");

  a_timer_tick_count: assert property ( // RULE_13
    (st_r.mode == event_timer_pkg::MODE_TIMER && st_r.run_enable
     && tick && !power_down) |-> inc)
    else $error("timer missed a prescaler tick");

  a_event_edge: assert property ( // RULE_02
    (st_r.mode == event_timer_pkg::MODE_EVENT && st_r.run_enable
     && (st_r.edge_sense_bit ? pin_fall : pin_rise)) |-> inc)
    else $error("event edge not counted");

  a_event_sleep: assert property ( // RULE_15
    (power_down && st_r.mode == event_timer_pkg::MODE_EVENT
     && st_r.run_enable && !wr_hi && pin_rise
     && !st_r.edge_sense_bit && st_r.count != 16'hffff) |=>
      st_r.count == $past(st_r.count) + 16'h0001)
    else $error("event count stalled in power down");

  a_wrap_reload: assert property ( // RULE_03
    (inc && st_r.count == event_timer_pkg::COUNT_FULL && !wr_hi) |=>
      (st_r.count == $past(st_r.preload)) && st_r.ovf)
    else $error("overflow did not reload preload");

  a_stop_load: assert property ( // RULE_04
    (wr_hi && !st_r.run_enable) |=>
      st_r.count == {$past(st_r.wdata), $past(st_r.low_buf)})
    else $error("stopped counter not loaded by write");

  a_run_preload: assert property ( // RULE_05
    (wr_hi && st_r.run_enable && !inc) |=>
      st_r.count == $past(st_r.count))
    else $error("running count changed by preload write");

  a_low_buffer: assert property ( // RULE_06
    (wr_lo && !inc) |=> (st_r.count == $past(st_r.count))
      && (st_r.preload == $past(st_r.preload)))
    else $error("low byte write leaked past buffer");

  a_hi_commit: assert property ( // RULE_07
    wr_hi |=> st_r.preload == {$past(st_r.wdata), $past(st_r.low_buf)})
    else $error("high write did not move buffered low");

  a_hi_latch: assert property ( // RULE_08
    (rd_hi && !wr_lo) |=> st_r.low_buf == $past(st_r.count[7:0]))
    else $error("high read did not latch low byte");

  a_irq_gate: assert property ( // RULE_14
    st_r.irq |-> st_r.ovf && $past(st_r.overflow_irq_mask))
    else $error("overflow request passed a cleared enable");

  a_pulse_stop: assert property ( // RULE_16
    (st_r.mode == event_timer_pkg::MODE_PULSE && st_r.run_enable
     && st_r.pw_st == event_timer_pkg::PW_MEAS && back_level
     && !wr_ctrl) |=> !st_r.run_enable ##1 !st_r.run_enable
       || $past(wr_ctrl))
    else $error("pulse end did not clear run enable");

  a_run_keep: assert property ( // RULE_18
    (st_r.mode != event_timer_pkg::MODE_PULSE && st_r.run_enable
     && !wr_ctrl) |=> st_r.run_enable)
    else $error("run enable cleared by hardware");

  a_done_hold: assert property ( // RULE_19
    (st_r.mode == event_timer_pkg::MODE_PULSE && !st_r.run_enable
     && !wr_hi && !wr_ctrl) |=> st_r.count == $past(st_r.count))
    else $error("count moved after pulse measurement");

  a_idle_mode: assert property ( // RULE_10
    (st_r.mode == event_timer_pkg::MODE_NONE) |-> !inc)
    else $error("counter moved with no mode selected");

  a_stop_no_inc: assert property ( // RULE_11
    !st_r.run_enable |-> !inc)
    else $error("stopped counter still counting");

  a_pulse_start: assert property ( // RULE_12
    (st_r.mode == event_timer_pkg::MODE_PULSE && st_r.run_enable
     && st_r.pw_st == event_timer_pkg::PW_WAIT && start_edge
     && !wr_ctrl) |=> st_r.pw_st == event_timer_pkg::PW_MEAS)
    else $error("pulse start edge not taken");

  a_pulse_high_end: assert property ( // RULE_17
    (st_r.mode == event_timer_pkg::MODE_PULSE && st_r.edge_sense_bit
     && st_r.run_enable && st_r.pw_st == event_timer_pkg::PW_MEAS
     && !st_r.sync2 && !wr_ctrl) |=> !st_r.run_enable)
    else $error("high pulse did not end on low level");

  a_sync_chain: assert property ( // RULE_21
    st_r.pin_prev == $past(st_r.sync2) && st_r.sync2 == $past(st_r.sync1))
    else $error("input pin skipped a synchroniser stage");

  a_irq_masked: assert property ( // RULE_14
    (inc && st_r.count == event_timer_pkg::COUNT_FULL
     && !st_r.overflow_irq_mask) |=> !st_r.irq)
    else $error("masked overflow still raised request");

  c_overflow:   cover property (st_r.ovf && st_r.irq);
  c_pulse_done: cover property (
    st_r.mode == event_timer_pkg::MODE_PULSE && $fell(st_r.run_enable));
  c_event_inc:  cover property (
    st_r.mode == event_timer_pkg::MODE_EVENT && inc);
  c_hi_read:    cover property (rd_hi);
  c_sleep_evt:  cover property (
    power_down && st_r.mode == event_timer_pkg::MODE_EVENT && inc);

endmodule : event_timer
`default_nettype wire

// ---- event_source.sv ----
`timescale 1ns/10ps
`default_nettype none
// Far-side pulse and event source; pin always driven, no pull
module event_source (
  input  wire logic aclk,
  output var logic  pin
);
  initial pin = 1'b0;

  // Level held a whole number of cycles; design needs at least one
  task automatic hold(input logic lvl, input int cyc);
    pin <= lvl;
    repeat (cyc) @(posedge aclk);
  endtask : hold

  task automatic burst(input int n);
    repeat (n) begin
      hold(1'b1, 3);
      hold(1'b0, 3);
    end
  endtask : burst
endmodule : event_source
`default_nettype wire

// ---- tb_event_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_event_timer;
  localparam logic [7:0] LO = event_timer_pkg::OFS_LOW;
  localparam logic [7:0] HI = event_timer_pkg::OFS_HIGH;
  localparam logic [7:0] CT = event_timer_pkg::OFS_CTRL;
  localparam logic [7:0] IE = event_timer_pkg::OFS_IRQ_EN;
  logic        aclk       = 1'b0;
  logic        aresetn    = 1'b0;
  logic [7:0]  awaddr     = 8'h00;
  logic        awvalid    = 1'b0;
  logic [31:0] wdata      = 32'h0;
  logic        wvalid     = 1'b0;
  logic [7:0]  araddr     = 8'h00;
  logic        arvalid    = 1'b0;
  logic        power_down = 1'b0;
  logic        bready     = 1'b0;
  logic        rready     = 1'b0;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic        pin;
  logic        irq;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic [7:0]  b;
  logic [15:0] c;
  logic [15:0] c2;
  int          s;
  int          n;
  int          irq_seen    = 0;
  int          err_count   = 0;
  int          comparisons = 0;

  always #20 aclk = ~aclk;

  // Prot unused; every write carries the low byte lane only
  event_timer i_event_timer (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .s_axi_awaddr    (awaddr),
    .s_axi_awprot    (3'h0),
    .s_axi_awvalid   (awvalid),
    .s_axi_awready   (awready),
    .s_axi_wdata     (wdata),
    .s_axi_wstrb     (4'h1),
    .s_axi_wvalid    (wvalid),
    .s_axi_wready    (wready),
    .s_axi_bresp     (bresp),
    .s_axi_bvalid    (bvalid),
    .s_axi_bready    (bready),
    .s_axi_araddr    (araddr),
    .s_axi_arprot    (3'h0),
    .s_axi_arvalid   (arvalid),
    .s_axi_arready   (arready),
    .s_axi_rdata     (rdata),
    .s_axi_rresp     (rresp),
    .s_axi_rvalid    (rvalid),
    .s_axi_rready    (rready),
    .event_input_pin (pin),
    .power_down      (power_down),
    .overflow_irq    (irq)
  );

  event_source i_event_source (
    .aclk (aclk),
    .pin  (pin)
  );

  always @(posedge aclk)
    if (aresetn && irq === 1'b1) irq_seen <= irq_seen + 1;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic timeout();
    err_count++;
    $display("CHECK FAILED at %0t: no answer", $time);
    conclude();
  endtask : timeout

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = 2'b00);
    int k;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready  <= 1'b0;
    if (k == 40) timeout();
    check({14'h0, bresp}, {14'h0, er});
    // Idle edge so a following call never reassigns bready at once
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    input logic [1:0] er = 2'b00);
    int k;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready  <= 1'b0;
    if (k == 40) timeout();
    d = rdata[7:0];
    check({14'h0, rresp}, {14'h0, er});
    check(rdata[31:16] | 16'(rdata[15:8]), 16'h0);
    @(posedge aclk);
  endtask : rd

  // High first so the low byte comes from the latch
  task automatic rdc(output logic [15:0] v);
    rd(HI, v[15:8]);
    rd(LO, v[7:0]);
  endtask : rdc

  task automatic ld(input logic [15:0] v);
    wr(LO, v[7:0]);
    wr(HI, v[15:8]);
  endtask : ld

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CT, b);
    check({8'h0, b}, 16'h0);
    rd(IE, b);
    check({8'h0, b}, 16'h0);
    rdc(c);
    check(c, 16'h0);
    rd(8'h10, b, 2'b10);
    check({8'h0, b}, 16'h0);
    wr(8'h10, 8'hff, 2'b10);
    $display("test registers done");
    wr(LO, 8'h34);
    rdc(c);
    check(c, 16'h0);
    // High read reused the shared buffer, so park the low byte again
    wr(LO, 8'h34);
    wr(HI, 8'h12);
    rdc(c);
    check(c, 16'h1234);
    $display("test byte access done");
    ld(16'h0000);
    wr(CT, 8'h80);
    repeat (40) @(posedge aclk);
    rdc(c);
    check(c, 16'h0);
    wr(CT, 8'h90);
    repeat (400) @(posedge aclk);
    wr(CT, 8'h80);
    rdc(c);
    check(16'(c >= 16'd99 && c <= 16'd102), 16'h1);
    wr(CT, 8'h10);
    repeat (40) @(posedge aclk);
    rdc(c2);
    check(c2, c);
    wr(CT, 8'h90);
    rd(HI, b);
    rd(LO, b);
    repeat (60) @(posedge aclk);
    rd(LO, c2[7:0]);
    check({8'h0, c2[7:0]}, {8'h0, b});
    $display("test interval done");
    wr(CT, 8'h80);
    ld(16'hffe0);
    wr(IE, 8'h01);
    wr(CT, 8'h90);
    ld(16'h8000);
    rd(HI, b);
    check({8'h0, b}, 16'h00ff);
    for (n = 0; n < 300 && irq_seen == 0; n++) @(posedge aclk);
    check(16'(irq_seen), 16'h1);
    rd(CT, b);
    check({8'h0, b}, 16'h0090);
    rd(HI, b);
    check({8'h0, b}, 16'h0080);
    wr(CT, 8'h80);
    wr(IE, 8'h00);
    ld(16'hfff8);
    wr(CT, 8'h90);
    repeat (100) @(posedge aclk);
    check(16'(irq_seen), 16'h1);
    wr(CT, 8'h80);
    $display("test overflow done");
    for (s = 0; s < 2; s++) begin
      i_event_source.hold(1'b0, 4);
      wr(CT, 8'h40);
      ld(16'h0);
      wr(CT, 8'h50 | 8'(s << 3));
      power_down <= 1'b1;
      i_event_source.hold(1'b1, 6);
      rdc(c);
      check(c, 16'(1 - s));
      i_event_source.hold(1'b0, 6);
      rdc(c);
      check(c, 16'h1);
      i_event_source.burst(3);
      rdc(c);
      check(c, 16'h4);
      power_down <= 1'b0;
    end
    $display("test events done");
    for (s = 0; s < 2; s++) begin
      i_event_source.hold(s == 0, 4);
      wr(CT, 8'hc0 | 8'(s << 3));
      ld(16'h0);
      wr(CT, 8'hd0 | 8'(s << 3));
      i_event_source.hold(s == 0, 20);
      rdc(c);
      check(c, 16'h0);
      i_event_source.hold(s != 0, 200);
      i_event_source.hold(s == 0, 10);
      rd(CT, b);
      check({8'h0, b}, {8'h0, 8'hc0 | 8'(s << 3)});
      rdc(c);
      check(16'(c >= 16'd48 && c <= 16'd52), 16'h1);
      i_event_source.hold(s != 0, 40);
      i_event_source.hold(s == 0, 10);
      rdc(c2);
      check(c2, c);
    end
    $display("test pulse width done");
    conclude();
  end
endmodule : tb_event_timer
`default_nettype wire
